// file: increment_and_bit_skip_exec_tb_top.sv
// Self-checking bench for the conditional-skip execution unit.
// Assumes skip_exec_pkg is compiled first; the bench drives all ports.
module increment_and_bit_skip_exec_tb_top
   import skip_exec_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Signals and case table
   localparam skip_op_e INC_M = OP_INC_MEM_SKIP_ZERO;
   localparam skip_op_e INC_A = OP_INC_TO_ACC_SKIP_ZERO;
   localparam skip_op_e BIT_S = OP_BIT_SKIP_NONZERO;

   typedef struct packed {
      exec_req_s req;
      exec_res_s res;
      logic      skip;
   } row_s;

   logic      clk_i       = 1'b0;
   logic      sys_rst_i   = 1'b1;
   logic      req_valid_i = 1'b0;
   exec_req_s req_i       = '0;
   exec_res_s res_o;
   logic      skip_o;
   logic      busy_o;
   logic      flags_we_o;
   int        fail_count  = 0;
   int        checks      = 0;

   // Wrap-around and bit-position corners; last row expects no activity
   row_s rows [11] = '{
      '{'{INC_M, 8'hff, 3'h0}, '{1'b1, 8'h00, 1'b0, 8'h00}, 1'b1},
      '{'{INC_M, 8'h7f, 3'h0}, '{1'b1, 8'h80, 1'b0, 8'h00}, 1'b0},
      '{'{INC_M, 8'h00, 3'h0}, '{1'b1, 8'h01, 1'b0, 8'h00}, 1'b0},
      '{'{INC_A, 8'hff, 3'h0}, '{1'b0, 8'h00, 1'b1, 8'h00}, 1'b1},
      '{'{INC_A, 8'hfe, 3'h0}, '{1'b0, 8'h00, 1'b1, 8'hff}, 1'b0},
      '{'{BIT_S, 8'h08, 3'h3}, '{1'b0, 8'h00, 1'b0, 8'h00}, 1'b1},
      '{'{BIT_S, 8'hf7, 3'h3}, '{1'b0, 8'h00, 1'b0, 8'h00}, 1'b0},
      '{'{BIT_S, 8'h80, 3'h7}, '{1'b0, 8'h00, 1'b0, 8'h00}, 1'b1},
      '{'{BIT_S, 8'h01, 3'h0}, '{1'b0, 8'h00, 1'b0, 8'h00}, 1'b1},
      '{'{BIT_S, 8'hfe, 3'h0}, '{1'b0, 8'h00, 1'b0, 8'h00}, 1'b0},
      '{'{OP_NONE, 8'hff, 3'h0}, '{1'b0, 8'h00, 1'b0, 8'h00}, 1'b0}
   };

   skip_exec dut (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .req_valid_i (req_valid_i),
      .req_i       (req_i),
      .res_o       (res_o),
      .skip_o      (skip_o),
      .busy_o      (busy_o),
      .flags_we_o  (flags_we_o)
   );

   always #10 clk_i = ~clk_i;

   // ==========================================================
   // Compare and report tasks
   task automatic chk_bit(string name, logic exp, logic got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %b, seen %b", name, exp, got);
      end
   endtask

   task automatic chk_byte(string name, logic [7:0] exp, logic [7:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // Data fields only compared when a write is due
   task automatic check_row(row_s w);
      chk_bit("mem_we", w.res.mem_we, res_o.mem_we);
      chk_bit("acc_we", w.res.acc_we, res_o.acc_we);
      if (w.res.mem_we) begin
         chk_byte("mem_wdata", w.res.mem_wdata, res_o.mem_wdata);
      end
      if (w.res.acc_we) begin
         chk_byte("acc_wdata", w.res.acc_wdata, res_o.acc_wdata);
      end
      chk_bit("skip", w.skip, skip_o);
      chk_bit("busy", w.skip, busy_o);
      chk_bit("flags_we", 1'b0, flags_we_o);
   endtask

   task automatic finish_test();
      $display("checks %0d, fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Sequence
   initial begin
      repeat (7) @(posedge clk_i);
      #1 check_row(rows[10]);
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (rows[i]) begin
         req_valid_i <= 1'b1;
         req_i       <= rows[i].req;
         @(posedge clk_i);
         req_valid_i <= 1'b0;
         #1 check_row(rows[i]);
         @(posedge clk_i);
      end
      // Held request during the dummy cycle must be ignored
      req_valid_i <= 1'b1;
      req_i       <= rows[0].req;
      @(posedge clk_i);
      #1 check_row(rows[0]);
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      #1 check_row(rows[10]);
      // Back-to-back non-skipping requests
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_i       <= rows[1].req;
      @(posedge clk_i);
      req_i       <= rows[4].req;
      #1 check_row(rows[1]);
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      #1 check_row(rows[4]);
      // Reset in mid-run wins over a request
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_i       <= rows[0].req;
      sys_rst_i   <= 1'b1;
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      sys_rst_i   <= 1'b0;
      #1 check_row(rows[10]);
      // Reset inside a dummy cycle, then a request straight after release
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_i       <= rows[0].req;
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      sys_rst_i   <= 1'b1;
      #1 check_row(rows[0]);
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_i       <= rows[5].req;
      sys_rst_i   <= 1'b0;
      #1 check_row(rows[10]);
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      #1 check_row(rows[5]);
      @(posedge clk_i);
      finish_test();
   end
endmodule

// file: skip_exec.sv
// Execution unit for three conditional-skip instructions.
// Assumes the core presents one request per instruction cycle on
// req_valid_i and holds off new requests while busy_o is high.
module skip_exec
   import skip_exec_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        req_valid_i,
   input  wire exec_req_s   req_i,
   output exec_res_s        res_o,
   output logic             skip_o,
   output logic             busy_o,
   output logic             flags_we_o
);

   // ==========================================================
   // Combinational result
   logic [DATA_W-1:0] inc_val;
   logic              inc_zero;
   logic              bit_set;
   logic              skip_take;
   exec_res_s         res_d;
   exec_res_s         res_q;
   exec_state_e       state_d;
   exec_state_e       state_q;
   logic              skip_d;
   logic              skip_q;

   assign inc_val  = req_i.mem_data + ONE_C;
   assign inc_zero = (inc_val == ZERO_C);
   assign bit_set  = req_i.mem_data[req_i.bit_sel];

   // Dummy cycle blocks requests so a skipped fetch never executes
   always_comb begin
      res_d     = '0;
      skip_take = 1'b0;
      state_d   = state_q;
      if (state_q == ST_DUMMY) begin
         // Dummy cycle: next fetch is discarded, nothing written
         state_d = ST_EXEC;
      end else if (req_valid_i) begin
         case (req_i.op)
            OP_INC_MEM_SKIP_ZERO: begin
               res_d.mem_we    = 1'b1;
               res_d.mem_wdata = inc_val;
               skip_take       = inc_zero;
            end
            OP_INC_TO_ACC_SKIP_ZERO: begin
               res_d.acc_we    = 1'b1;
               res_d.acc_wdata = inc_val;
               skip_take       = inc_zero;
            end
            OP_BIT_SKIP_NONZERO: begin
               skip_take = bit_set;
            end
            default: begin
               skip_take = 1'b0;
            end
         endcase
         if (skip_take) begin
            state_d = ST_DUMMY;
         end
      end
      skip_d = skip_take;
   end

   // ==========================================================
   // State registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         res_q   <= '0;
         state_q <= ST_EXEC;
         skip_q  <= 1'b0;
      end else begin
         res_q   <= res_d;
         state_q <= state_d;
         skip_q  <= skip_d;
      end
   end

   // ==========================================================
   // Outputs
   assign res_o      = res_q;
   assign skip_o     = skip_q;
   assign busy_o     = (state_q == ST_DUMMY);
   // Flags never touched by these instructions
   assign flags_we_o = 1'b0;

   // ==========================================================
   // Assertions
   // Request as the core sees it taken; reset beats a request
   logic              req_taken;
   assign req_taken = req_valid_i && !busy_o && !sys_rst_i;

   property p_inc_mem;
      @(posedge clk_i) disable iff (sys_rst_i)
      (req_taken && req_i.op == OP_INC_MEM_SKIP_ZERO)
      |=> (res_o.mem_we && res_o.mem_wdata ==
           $past(req_i.mem_data) + ONE_C
           && skip_o == ($past(req_i.mem_data) == 8'hff));
   endproperty
   a_inc_mem: assert property (p_inc_mem)
      else $error("memory increment or skip wrong");

   property p_acc_only;
      @(posedge clk_i) disable iff (sys_rst_i)
      (req_taken && req_i.op == OP_INC_TO_ACC_SKIP_ZERO)
      |=> (res_o.acc_we && !res_o.mem_we
           && res_o.acc_wdata == $past(req_i.mem_data) + ONE_C);
   endproperty
   a_acc_only: assert property (p_acc_only)
      else $error("accumulator variant touched memory");

   property p_dummy;
      @(posedge clk_i) disable iff (sys_rst_i)
      skip_o |-> busy_o ##1 (!busy_o && !res_o.mem_we && !res_o.acc_we);
   endproperty
   a_dummy: assert property (p_dummy)
      else $error("skip without one dummy cycle");

   property p_no_skip_nonzero;
      @(posedge clk_i) disable iff (sys_rst_i)
      (req_taken && req_i.op != OP_BIT_SKIP_NONZERO
       && req_i.op != OP_NONE && req_i.mem_data != 8'hff)
      |=> (!skip_o && !busy_o);
   endproperty
   a_no_skip_nonzero: assert property (p_no_skip_nonzero)
      else $error("skip on non-zero increment");

   property p_bit_set;
      @(posedge clk_i) disable iff (sys_rst_i)
      (req_taken && req_i.op == OP_BIT_SKIP_NONZERO
       && req_i.mem_data[req_i.bit_sel])
      |=> (skip_o && !res_o.mem_we && !res_o.acc_we);
   endproperty
   a_bit_set: assert property (p_bit_set)
      else $error("set bit did not skip");

   property p_bit_clr;
      @(posedge clk_i) disable iff (sys_rst_i)
      (req_taken && req_i.op == OP_BIT_SKIP_NONZERO
       && !req_i.mem_data[req_i.bit_sel]) |=> !skip_o;
   endproperty
   a_bit_clr: assert property (p_bit_clr)
      else $error("clear bit skipped");

   property p_flags;
      @(posedge clk_i) disable iff (sys_rst_i)
      $rose(skip_o) |-> !flags_we_o ##1 !flags_we_o;
   endproperty
   a_flags: assert property (p_flags)
      else $error("status flags written");

   property p_skip_source;
      @(posedge clk_i) disable iff (sys_rst_i)
      skip_o |-> $past(req_valid_i) && !$past(busy_o);
   endproperty
   a_skip_source: assert property (p_skip_source)
      else $error("skip without request");

   property p_refused;
      @(posedge clk_i) disable iff (sys_rst_i)
      (req_valid_i && busy_o) |=> (!skip_o && res_o == '0);
   endproperty
   a_refused: assert property (p_refused)
      else $error("request taken during dummy cycle");

   property p_acc_skip;
      @(posedge clk_i) disable iff (sys_rst_i)
      (req_taken && req_i.op == OP_INC_TO_ACC_SKIP_ZERO)
      |=> (skip_o == ($past(req_i.mem_data) == 8'hff));
   endproperty
   a_acc_skip: assert property (p_acc_skip)
      else $error("accumulator increment skip wrong");

   property p_busy_one;
      @(posedge clk_i) disable iff (sys_rst_i)
      busy_o |=> !busy_o;
   endproperty
   a_busy_one: assert property (p_busy_one)
      else $error("dummy cycle longer than one cycle");

   property p_skip_busy;
      @(posedge clk_i) disable iff (sys_rst_i)
      skip_o == busy_o;
   endproperty
   a_skip_busy: assert property (p_skip_busy)
      else $error("dummy cycle not aligned with skip");

   property p_bit_no_write;
      @(posedge clk_i) disable iff (sys_rst_i)
      (req_taken && req_i.op == OP_BIT_SKIP_NONZERO)
      |=> (!res_o.mem_we && !res_o.acc_we);
   endproperty
   a_bit_no_write: assert property (p_bit_no_write)
      else $error("bit test wrote a result");

   // Reset must end a pending dummy cycle, not defer it
   property p_rst_quiet;
      @(posedge clk_i)
      sys_rst_i |=> (!skip_o && !busy_o && res_o == '0);
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("skip or write survived reset");

   // ==========================================================
   // Coverage
   c_inc_wrap: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      res_o.mem_we && skip_o);
   c_acc_wrap: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      res_o.acc_we && skip_o);
   c_bit_skip: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      skip_o && !res_o.mem_we && !res_o.acc_we);
   c_no_skip: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      res_o.mem_we && !skip_o);
   c_refused: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      req_valid_i && busy_o);

endmodule

// file: skip_exec_pkg.sv
// Package for the increment-and-skip / bit-skip execution block.
// Assumes a single 50 MHz core clock with one-cycle instruction strobes.
package skip_exec_pkg;

   // ==========================================================
   // Widths
   localparam int unsigned DATA_W = 8;
   localparam int unsigned BIT_W  = 3;

   // ==========================================================
   // Constants
   localparam logic [DATA_W-1:0] ONE_C   = 8'h01;
   localparam logic [DATA_W-1:0] ZERO_C  = 8'h00;
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;

   // ==========================================================
   // Operations
   typedef enum logic [1:0] {
      OP_NONE,
      OP_INC_MEM_SKIP_ZERO,
      OP_INC_TO_ACC_SKIP_ZERO,
      OP_BIT_SKIP_NONZERO
   } skip_op_e;

   // Request carried from the decoder
   typedef struct packed {
      skip_op_e          op;
      logic [DATA_W-1:0] mem_data;
      logic [BIT_W-1:0]  bit_sel;
   } exec_req_s;

   // Results handed back to the core
   typedef struct packed {
      logic              mem_we;
      logic [DATA_W-1:0] mem_wdata;
      logic              acc_we;
      logic [DATA_W-1:0] acc_wdata;
   } exec_res_s;

   // Execution phases
   typedef enum logic [0:0] {
      ST_EXEC,
      ST_DUMMY
   } exec_state_e;

endpackage
